// file: dv/tes_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// Drive side timing sensors; one track can be made to lose its signal
module tes_drive_model
  import tes_pkg::*;
(
  input wire logic clk,
  input wire logic drop,
  output logic [TES_TRACKS7-1:0] sensor_active
);
  // Registered, as a real sensor lags the tape by at least a cycle
  always_ff @(posedge clk) begin
    sensor_active <= drop ? 7'h5F : 7'h7F;
  end
endmodule
`default_nettype wire

// file: dv/tes_error_sense_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tes_error_sense_bench
  import tes_pkg::*;
;
  logic clk = 0, reset = 1, op_active = 0, op_end = 0, byte_to_channel = 0, read_stop_delay = 0, drop = 0;
  logic data_expected = 1, write_char_valid = 0, sense_read_done = 0, data_check_ind, partial_record;
  tes_ctrl_t ctrl = '0;
  tes_read_stat_t rd_stat = '0;
  logic [6:0] track_sensor_active, write_char = '0, write_bus_to_drive, read_pulse_return, wb_prev = '0;
  logic [7:0] sense_byte1, sense_byte3, sense_byte5;
  logic [23:0] sq[$]; // Expected sense bytes, oldest first
  logic [6:0] wq[$]; // Expected write characters
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #12.5 clk = ~clk;
  tes_error_sense dut (.clk, .reset, .ctrl, .rd_stat, .track_sensor_active, .op_active, .op_end,
    .byte_to_channel, .read_stop_delay, .data_expected, .write_char_valid, .write_char, .sense_read_done,
    .sense_byte1, .sense_byte3, .sense_byte5, .data_check_ind, .partial_record, .write_bus_to_drive,
    .read_pulse_return);
  tes_drive_model drv (.clk, .drop, .sensor_active(track_sensor_active));
  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One cause per operation; f: drop, no data expected, stop delay, op end, byte sent
  task automatic run(tes_mode_t m, tes_op_t o, tes_read_stat_t s, logic [4:0] f, logic [23:0] e);
    @(posedge clk);
    ctrl.mode <= m;
    ctrl.op <= o;
    op_active <= 1;
    drop <= f[0];
    data_expected <= !f[1];
    read_stop_delay <= f[2];
    byte_to_channel <= f[4];
    @(posedge clk);
    rd_stat <= s;
    op_end <= f[3];
    byte_to_channel <= 0;
    @(posedge clk);
    {rd_stat, op_end, drop, read_stop_delay, op_active} <= '0;
    data_expected <= 1;
    // Bits must still stand a few cycles later, until the host reads
    repeat (3) @(posedge clk);
    sq.push_back(e);
    sense_read_done <= 1;
    @(posedge clk);
    sense_read_done <= 0;
  endtask
  // Two characters per density; the gap between them is the character period
  task automatic wr(tes_density_t d, int per);
    logic [6:0] c;
    int n;
    @(posedge clk);
    ctrl <= '{TES_MODE_NRZI7, TES_OP_WRITE, d, 1'b1, 1'b0, 1'b0};
    {op_active, write_char_valid} <= 2'h3;
    write_char <= 7'h7F;
    wq.push_back(7'h3F);
    n = 0;
    while (write_bus_to_drive === '0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    c = {1'($urandom), 6'($urandom_range(62, 1))};
    write_char <= c;
    wq.push_back(c);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (write_bus_to_drive !== '0 && n < 3000);
    check("width", 24'(TES_PULSE_CYC), 24'(n));
    do begin
      @(posedge clk);
      n++;
    end while (write_bus_to_drive === '0 && n < 3000);
    check("period", 24'(per), 24'(n));
    {op_active, write_char_valid} <= 2'h0;
    repeat (60) @(posedge clk);
  endtask
  // Host reads sense: the oldest note must match what is held
  always @(posedge clk) begin
    if (sense_read_done && sq.size() > 0) check("sense", sq.pop_front(), {sense_byte1, sense_byte3, sense_byte5});
  end
  // Each new write pulse is compared with the character it should carry
  always @(posedge clk) begin
    wb_prev <= write_bus_to_drive;
    if (write_bus_to_drive !== '0 && wb_prev === '0 && wq.size() > 0) check("wbus", 24'(wq.pop_front()), 24'(write_bus_to_drive));
  end
  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    void'($urandom(77));
    repeat (10) @(posedge clk);
    reset <= 0;
    run(TES_MODE_PE, TES_OP_WRITE, 7'h40, 5'h00, 24'h001000);
    run(TES_MODE_NRZI7, TES_OP_READ_FWD, 7'h20, 5'h00, 24'h001000);
    run(TES_MODE_PE, TES_OP_READ_FWD, 7'h00, 5'h01, 24'h001000);
    run(TES_MODE_GCR6250, TES_OP_WRITE, 7'h00, 5'h01, 24'h001000);
    run(TES_MODE_GCR6250, TES_OP_READ_BWD, 7'h08, 5'h00, 24'h010000);
    run(TES_MODE_NRZI7, TES_OP_READ_FWD, 7'h04, 5'h04, 24'h010000);
    run(TES_MODE_PE, TES_OP_READ_BWD, 7'h04, 5'h02, 24'h010000);
    run(TES_MODE_PE, TES_OP_READ_FWD, 7'h04, 5'h00, 24'h000000);
    run(TES_MODE_NRZI9, TES_OP_ERASE_GAP, 7'h04, 5'h00, 24'h010000);
    run(TES_MODE_GCR6250, TES_OP_WRITE_MARK, 7'h04, 5'h00, 24'h010000);
    run(TES_MODE_PE, TES_OP_READ_FWD, 7'h02, 5'h00, 24'h000020);
    run(TES_MODE_PE, TES_OP_READ_FWD, 7'h03, 5'h00, 24'h000060);
    run(TES_MODE_NRZI9, TES_OP_READ_BWD, 7'h00, 5'h08, 24'h010000);
    run(TES_MODE_GCR6250, TES_OP_READ_FWD, 7'h00, 5'h18, 24'h000000);
    wr(TES_DEN_200, TES_CHAR_CYC_200);
    wr(TES_DEN_556, TES_CHAR_CYC_556);
    wr(TES_DEN_800, TES_CHAR_CYC_800);
    repeat (5) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire

// file: dv/tes_error_sense_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Ties each sense output to the input condition that caused it
module tes_error_sense_sva
  import tes_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire tes_ctrl_t ctrl,
  input wire tes_read_stat_t rd_stat,
  input wire logic op_active,
  input wire logic read_stop_delay,
  input wire logic data_expected,
  input wire logic [TES_TRACKS7-1:0] track_sensor_active,
  input wire logic sense_read_done,
  input wire logic [7:0] sense_byte1,
  input wire logic [7:0] sense_byte3,
  input wire logic [7:0] sense_byte5,
  input wire logic data_check_ind,
  input wire logic partial_record,
  input wire logic [TES_TRACKS7-1:0] write_bus_to_drive,
  input wire logic [TES_TRACKS7-1:0] read_pulse_return
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Read in a block-coded mode, and any active NRZI operation
  wire logic rd_hd = op_active && ctrl.mode inside {TES_MODE_PE, TES_MODE_GCR6250}
    && ctrl.op inside {TES_OP_READ_FWD, TES_OP_READ_BWD};
  wire logic nz = op_active && ctrl.mode inside {TES_MODE_NRZI7, TES_MODE_NRZI9};
  sequence gap_seen;
    rd_stat.interblock_gap;
  endsequence
  sequence phase_slip;
    ctrl.mode == TES_MODE_PE && ctrl.op == TES_OP_WRITE && rd_stat.phase_error_pointer;
  endsequence
  phase_env_a:
    assert property (phase_slip |=> sense_byte3[TES_B3_ENV_BIT] && data_check_ind) else $error("phase slip missed");
  clip_env_a:
    assert property (nz && rd_stat.high_clip_parity_error |=> sense_byte3[TES_B3_ENV_BIT]) else $error("clip missed");
  check_noise_a:
    assert property (rd_hd && rd_stat.data_check |=> sense_byte1[TES_B1_NOISE_BIT]) else $error("check noise missed");
  stop_noise_a:
    assert property (nz && ctrl.op inside {TES_OP_READ_FWD, TES_OP_READ_BWD} && read_stop_delay
      && rd_stat.data_detected |=> sense_byte1[TES_B1_NOISE_BIT]) else $error("stop delay noise missed");
  sensor_env_a:
    assert property (rd_hd && track_sensor_active != '1 |=> sense_byte3[TES_B3_ENV_BIT])
      else $error("sensor loss missed");
  quiet_noise_a:
    assert property (op_active && ctrl.mode inside {TES_MODE_PE, TES_MODE_GCR6250} && !data_expected
      && rd_stat.data_detected |=> sense_byte1[TES_B1_NOISE_BIT]) else $error("unexpected data noise missed");
  gap_noise_a:
    assert property (op_active && ctrl.op inside {TES_OP_ERASE_GAP, TES_OP_WRITE_MARK} && rd_stat.data_detected
      |=> sense_byte1[TES_B1_NOISE_BIT]) else $error("erase noise missed");
  gap_partial_a:
    assert property (gap_seen |=> sense_byte5[TES_B5_PARTIAL_BIT]) else $error("gap not flagged");
  partial_view_a:
    assert property (partial_record == (ctrl.mode == TES_MODE_PE && sense_byte5[5] && !sense_byte5[6]))
      else $error("partial record wrong");
  noise_hold_a:
    assert property (sense_byte1[0] && !sense_read_done |=> sense_byte1[0]) else $error("noise dropped");
  partial_clear_a:
    assert property (sense_read_done && !rd_stat.interblock_gap |=> !sense_byte5[5]) else $error("partial not cleared");
  echo_track_a:
    assert property (read_pulse_return == $past(write_bus_to_drive)) else $error("read pulse not echo");
endmodule
bind tes_error_sense tes_error_sense_sva chk (.clk, .reset, .ctrl, .rd_stat, .op_active, .read_stop_delay,
  .data_expected, .track_sensor_active,
  .sense_read_done, .sense_byte1, .sense_byte3, .sense_byte5, .data_check_ind, .partial_record,
  .write_bus_to_drive, .read_pulse_return);
`default_nettype wire

// file: src/tes_error_sense.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - PE write phase error sets envelope, data check
// - NRZI high-clip parity error sets envelope
// - Timing sensor loss on PE read or 6250 read/write sets envelope, as signal_loss_error does
// - Data check on 6250/PE read sets noise
// - Read with no transfer sets noise
// - Data during NRZI stop delay sets noise
// - Unexpected data in 6250/PE sets noise
// - Data during erase gap or mark sets noise
// - Interblock gap sets partial record bit
// - All-ones even parity, no converter, no translate: no parity-track pulse
// - Same NRZI sequence, interval scaled by density
// - PE partial record: bit5 on, bit6 off
module tes_error_sense
  import tes_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire tes_ctrl_t ctrl,
  input wire tes_read_stat_t rd_stat,
  input wire logic [TES_TRACKS7-1:0] track_sensor_active,
  input wire logic op_active,
  input wire logic op_end,
  input wire logic byte_to_channel,
  input wire logic read_stop_delay,
  input wire logic data_expected,
  input wire logic write_char_valid,
  input wire logic [TES_TRACKS7-1:0] write_char,
  input wire logic sense_read_done,
  output logic [7:0] sense_byte1,
  output logic [7:0] sense_byte3,
  output logic [7:0] sense_byte5,
  output logic data_check_ind,
  output logic partial_record,
  output logic [TES_TRACKS7-1:0] write_bus_to_drive,
  output logic [TES_TRACKS7-1:0] read_pulse_return
);

  logic env_r;                // Envelope check
  logic env_nxt;
  logic noise_r;              // Noise
  logic noise_nxt;
  logic partial_r;            // Interblock gap seen
  logic partial_nxt;
  logic excess_r;             // Excess postamble companion bit
  logic excess_nxt;
  logic dchk_r;               // Data check indication
  logic dchk_nxt;
  logic xfer_r;               // Any byte sent this operation
  logic xfer_nxt;
  logic [TES_TRACKS7-1:0] wchar_r; // Character held for the write pulse
  logic [TES_TRACKS7-1:0] wchar_nxt;
  logic [TES_TRACKS7-1:0] wbus_r;
  logic [TES_TRACKS7-1:0] wbus_nxt;
  logic [TES_TRACKS7-1:0] rpulse_r;
  logic [TES_TRACKS7-1:0] rpulse_nxt;
  logic char_start;
  logic pulse_active;
  logic nrzi7_write;
  logic is_read;
  logic pe_or_gcr;
  logic is_nrzi;
  logic set_env;
  logic set_noise;
  logic set_dchk;

  // Mode decoding used in several places
  function automatic logic fast_mode(input tes_mode_t m);
    return (m == TES_MODE_PE) || (m == TES_MODE_GCR6250);
  endfunction

  function automatic logic read_op(input tes_op_t o);
    return (o == TES_OP_READ_FWD) || (o == TES_OP_READ_BWD);
  endfunction

  assign pe_or_gcr = fast_mode(ctrl.mode);
  assign is_read = read_op(ctrl.op);
  assign is_nrzi = !pe_or_gcr;
  assign nrzi7_write = (ctrl.mode == TES_MODE_NRZI7) && (ctrl.op == TES_OP_WRITE);

  // Character pacing for 7-track writing
  tes_nrzi_timer u_timer (
    .clk(clk),
    .reset(reset),
    .run(nrzi7_write && op_active),
    .density(ctrl.density),
    .char_start(char_start),
    .pulse_active(pulse_active)
  );

  // Envelope and data check set conditions
  always_comb begin
    set_env = 1'b0;
    set_dchk = 1'b0;
    if (ctrl.mode == TES_MODE_PE && ctrl.op == TES_OP_WRITE && rd_stat.phase_error_pointer) begin
      set_env = 1'b1;
      set_dchk = 1'b1;
    end
    if (is_nrzi && rd_stat.high_clip_parity_error) begin
      set_env = 1'b1;
    end
    // Loss of any track's timing sensor, or the read path's signal_loss_error flag
    if (op_active && ((ctrl.mode == TES_MODE_PE && is_read) ||
        (ctrl.mode == TES_MODE_GCR6250 && (is_read || ctrl.op == TES_OP_WRITE))) &&
        ((~track_sensor_active != '0) || rd_stat.signal_loss_error)) begin
      set_env = 1'b1;
    end
  end

  // Noise set conditions
  always_comb begin
    set_noise = 1'b0;
    if (pe_or_gcr && is_read && (rd_stat.data_check || set_dchk)) begin
      set_noise = 1'b1;
    end
    // A read ends with nothing sent; byte in the ending cycle still counts
    if (is_read && op_end && !xfer_r && !byte_to_channel) begin
      set_noise = 1'b1;
    end
    if (is_nrzi && is_read && read_stop_delay && rd_stat.data_detected) begin
      set_noise = 1'b1;
    end
    if (pe_or_gcr && op_active && !data_expected && rd_stat.data_detected) begin
      set_noise = 1'b1;
    end
    if ((ctrl.op == TES_OP_ERASE_GAP || ctrl.op == TES_OP_WRITE_MARK) && rd_stat.data_detected) begin
      set_noise = 1'b1;
    end
  end

  // Sticky sense bits: set wins over the clear from a sense read
  always_comb begin
    env_nxt = set_env | (env_r & ~sense_read_done);
    noise_nxt = set_noise | (noise_r & ~sense_read_done);
    dchk_nxt = set_dchk | (dchk_r & ~sense_read_done);
    partial_nxt = rd_stat.interblock_gap | (partial_r & ~sense_read_done);
    excess_nxt = rd_stat.excess_postamble | (excess_r & ~sense_read_done);
    // Transfer tracker restarts at each operation end
    if (op_end) begin
      xfer_nxt = 1'b0;
    end else begin
      xfer_nxt = xfer_r | (op_active & byte_to_channel);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      env_r <= 1'b0;
      noise_r <= 1'b0;
      dchk_r <= 1'b0;
      partial_r <= 1'b0;
      excess_r <= 1'b0;
      xfer_r <= 1'b0;
    end else begin
      env_r <= env_nxt;
      noise_r <= noise_nxt;
      dchk_r <= dchk_nxt;
      partial_r <= partial_nxt;
      excess_r <= excess_nxt;
      xfer_r <= xfer_nxt;
    end
  end

  // 7-track write shaping: pulse per one bit, fixed width, then idle
  always_comb begin
    wchar_nxt = wchar_r;
    if (!nrzi7_write) begin
      wchar_nxt = '0;
    end else if (char_start) begin
      // No character offered: the period stays blank rather than repeating the last one
      wchar_nxt = write_char_valid ? write_char : '0;
      // All-ones with even parity, no converter, no translate: no parity flux
      if (write_char_valid && ctrl.parity_even && !ctrl.data_converter && !ctrl.translate &&
          (write_char[TES_PARITY_TRACK-1:0] == '1)) begin
        wchar_nxt[TES_PARITY_TRACK] = 1'b0;
      end
    end
    // Same sequence at each density, only the period differs
    wbus_nxt = pulse_active ? wchar_r : '0;
    // Read-back mirrors what was written, so the parity track stays quiet too
    rpulse_nxt = wbus_r;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wchar_r <= '0;
      wbus_r <= '0;
      rpulse_r <= '0;
    end else begin
      wchar_r <= wchar_nxt;
      wbus_r <= wbus_nxt;
      rpulse_r <= rpulse_nxt;
    end
  end

  // Sense byte assembly; unused bits read zero
  always_comb begin
    sense_byte1 = TES_SENSE_RESET;
    sense_byte3 = TES_SENSE_RESET;
    sense_byte5 = TES_SENSE_RESET;
    sense_byte1[TES_B1_NOISE_BIT] = noise_r;
    sense_byte3[TES_B3_ENV_BIT] = env_r;
    sense_byte5[TES_B5_PARTIAL_BIT] = partial_r;
    sense_byte5[TES_B5_EXCESS_BIT] = excess_r;
  end

  assign data_check_ind = dchk_r;
  assign partial_record = (ctrl.mode == TES_MODE_PE) && partial_r && !excess_r;
  assign write_bus_to_drive = wbus_r;
  assign read_pulse_return = rpulse_r;

endmodule
`default_nettype wire

// file: src/tes_nrzi_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Paces 7-track NRZI characters; one sequence, period scaled by density
module tes_nrzi_timer
  import tes_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire tes_density_t density,
  output logic char_start,
  output logic pulse_active
);

  logic [TES_CNT_W-1:0] cnt_r;
  logic [TES_CNT_W-1:0] cnt_nxt;
  logic [TES_CNT_W-1:0] period;

  // Only the period length depends on density
  always_comb begin
    unique case (density)
      TES_DEN_200: period = TES_CNT_W'(TES_CHAR_CYC_200);
      TES_DEN_556: period = TES_CNT_W'(TES_CHAR_CYC_556);
      TES_DEN_800: period = TES_CNT_W'(TES_CHAR_CYC_800);
      default: period = TES_CNT_W'(TES_CHAR_CYC_800);
    endcase
  end

  // Next count: wraps at the period, parks at zero when idle
  always_comb begin
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r >= period - TES_CNT_W'(1)) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + TES_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign char_start = run && (cnt_r == '0);
  // Window opens one count after the character is taken, so the held character
  // is already the new one when the first pulse cycle is latched; no stale flux
  assign pulse_active = run && (cnt_r != '0) && (cnt_r <= TES_CNT_W'(TES_PULSE_CYC));

endmodule
`default_nettype wire

// file: src/tes_pkg.sv
package tes_pkg;

  // Recording modes the control can run in
  typedef enum logic [1:0] {
    TES_MODE_PE,
    TES_MODE_GCR6250,
    TES_MODE_NRZI7,
    TES_MODE_NRZI9
  } tes_mode_t;

  // Operation in progress
  typedef enum logic [2:0] {
    TES_OP_IDLE,
    TES_OP_READ_FWD,
    TES_OP_READ_BWD,
    TES_OP_WRITE,
    TES_OP_ERASE_GAP,
    TES_OP_WRITE_MARK
  } tes_op_t;

  // 7-track NRZI densities
  typedef enum logic [1:0] {
    TES_DEN_200,
    TES_DEN_556,
    TES_DEN_800
  } tes_density_t;

  // Mode and operation controls from the microprogram side
  typedef struct packed {
    tes_mode_t mode;
    tes_op_t op;
    tes_density_t density;
    logic parity_even;
    logic data_converter;
    logic translate;
  } tes_ctrl_t;

  // Read-back status from the read path
  typedef struct packed {
    logic phase_error_pointer;
    logic high_clip_parity_error;
    logic signal_loss_error;
    logic data_check;
    logic data_detected;
    logic interblock_gap;
    logic excess_postamble;
  } tes_read_stat_t;

  // Sense byte field positions
  localparam int TES_B1_NOISE_BIT = 0;
  localparam int TES_B3_ENV_BIT = 4;
  localparam int TES_B5_PARTIAL_BIT = 5;
  localparam int TES_B5_EXCESS_BIT = 6;
  localparam logic [7:0] TES_SENSE_RESET = 8'h00;

  // Track count of a 7-track frame (P plus six data)
  localparam int TES_TRACKS7 = 7;
  localparam int TES_PARITY_TRACK = 6;

  // Clock rate in MHz, NRZI character periods in ns
  localparam int TES_CLK_MHZ = 40;
  localparam int TES_CHAR_NS_200 = 40000;
  localparam int TES_CHAR_NS_556 = 14388;
  localparam int TES_CHAR_NS_800 = 10000;
  localparam int TES_CHAR_CYC_200 = (TES_CHAR_NS_200 * TES_CLK_MHZ) / 1000;
  localparam int TES_CHAR_CYC_556 = (TES_CHAR_NS_556 * TES_CLK_MHZ) / 1000;
  localparam int TES_CHAR_CYC_800 = (TES_CHAR_NS_800 * TES_CLK_MHZ) / 1000;
  // Write pulse width inside a character period, in ns
  localparam int TES_PULSE_NS = 1000;
  localparam int TES_PULSE_CYC = (TES_PULSE_NS * TES_CLK_MHZ + 999) / 1000;
  localparam int TES_CNT_W = 16;

endpackage
